// ---- design/line_frame_sync.sv ----
`include "sync_params.svh"
module line_frame_sync #(
  parameter int unsigned FRAME_OLD_CYC = `FRAME_OLD_CYC,
  parameter int unsigned FRAME_NEW_CYC = `FRAME_NEW_CYC,
  parameter int unsigned TOL_PCT       = `FRAME_TOL_PCT,
  parameter int unsigned LINE_CYC_MAX  = 65535,
  parameter int unsigned MISS_MAX      = 2
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire sync_pkg::format_t i_format,
  input  wire logic             i_video_pulse,
  input  wire logic             i_line_pulse,
  input  wire logic             i_frame_window_en,
  input  wire logic             i_frame_window,
  input  wire logic             i_line_window_en,
  input  wire logic             i_line_window,
  input  wire logic             i_manual_start,
  input  wire logic             i_synth_frame,
  input  wire logic             i_frame_irq_ack,
  input  wire logic             i_line_irq_ack,
  output logic                  o_frame_irq,
  output logic                  o_line_irq,
  output logic                  o_line_time_zero,
  output logic                  o_phase_reset,
  output logic                  o_first_byte_mark,
  output logic                  o_zero_correct,
  output logic                  o_line_missing,
  output logic [1:0]            o_miss_count
);
  import sync_pkg::*;

  localparam int unsigned CW = 32;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The bridged-line count is two bits wide.
  if (MISS_MAX < 1 || MISS_MAX > 3) begin : g_bad_miss_max
    $error("MISS_MAX must lie between 1 and 3.");
  end
  // A band of 100 percent or more would accept a pulse of no width.
  if (TOL_PCT >= 100) begin : g_bad_tol_pct
    $error("TOL_PCT must stay below 100.");
  end
  if (FRAME_OLD_CYC < 2 || FRAME_NEW_CYC < 2) begin : g_bad_frame_cyc
    $error("Frame widths must be at least two cycles.");
  end
  // The band must end below the width counter's saturation value.
  if (64'(FRAME_OLD_CYC) * 64'(100 + TOL_PCT) >= 64'h63_FFFF_FF9C ||
      64'(FRAME_NEW_CYC) * 64'(100 + TOL_PCT) >= 64'h63_FFFF_FF9C) begin : g_bad_band
    $error("Frame width band exceeds the width counter.");
  end
  // A learnt line period must hold at least two cycles.
  if (LINE_CYC_MAX < 2) begin : g_bad_line_max
    $error("LINE_CYC_MAX must be at least two.");
  end

  // ----------------------------------------------------------------
  // Frame pulse width measurement
  // ----------------------------------------------------------------
  logic [CW-1:0] fwidth_r;
  logic          video_d_r;
  logic [CW-1:0] nominal;
  logic [CW-1:0] lo_lim;
  logic [CW-1:0] hi_lim;
  logic          frame_end;
  logic          frame_ok;
  logic          frame_evt;

  always_comb begin
    nominal = (i_format == FMT_NEW) ? CW'(FRAME_NEW_CYC) : CW'(FRAME_OLD_CYC);
    lo_lim  = CW'((64'(nominal) * 64'(100 - TOL_PCT)) / 64'd100);
    hi_lim  = CW'((64'(nominal) * 64'(100 + TOL_PCT)) / 64'd100);
  end

  // [RULE_01] Width counter.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      fwidth_r  <= '0;
      video_d_r <= 1'b0;
    end else begin
      video_d_r <= i_video_pulse;
      if (!i_video_pulse) begin
        fwidth_r <= '0;
      end else if (fwidth_r != '1) begin
        fwidth_r <= fwidth_r + 1'b1;
      end
    end
  end

  // Trailing edge with the width still held in the counter.
  assign frame_end = video_d_r && !i_video_pulse;
  // [RULE_14] Tolerance band check.
  assign frame_ok  = frame_end && (fwidth_r >= lo_lim) && (fwidth_r <= hi_lim)
                     && (!i_frame_window_en || i_frame_window);
  // [RULE_07] Manual start accepted.
  assign frame_evt = frame_ok || i_manual_start || i_synth_frame;

  // ----------------------------------------------------------------
  // Line sync trailing edge
  // ----------------------------------------------------------------
  logic          line_d_r;
  logic          line_evt;
  logic [CW-1:0] lcount_r;
  logic [CW-1:0] lperiod_r;
  logic          period_known_r;
  logic          miss_tick;
  logic          from_real_r;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      line_d_r <= 1'b0;
    end else begin
      line_d_r <= i_line_pulse;
    end
  end

  // [RULE_03] Trailing edge, gated by window.
  assign line_evt = line_d_r && !i_line_pulse && (!i_line_window_en || i_line_window);

  // Period learnt from the last good line, so a dropped pulse can be bridged.
  assign miss_tick = period_known_r && !line_evt && (lcount_r >= lperiod_r)
                     && (o_miss_count < 2'(MISS_MAX));

  // [RULE_10] Flywheel over missed lines.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      lcount_r       <= '0;
      lperiod_r      <= '0;
      period_known_r <= 1'b0;
      o_miss_count   <= 2'h0;
      o_line_missing <= 1'b0;
    end else begin
      if (frame_evt) begin
        lcount_r       <= '0;
        period_known_r <= 1'b0;
        o_miss_count   <= 2'h0;
        o_line_missing <= 1'b0;
      end else if (line_evt) begin
        if (from_real_r && lcount_r != '0 && lcount_r <= CW'(LINE_CYC_MAX)) begin
          lperiod_r      <= lcount_r;
          period_known_r <= 1'b1;
        end
        lcount_r       <= 'd1;
        o_miss_count   <= 2'h0;
        o_line_missing <= 1'b0;
      end else if (miss_tick) begin
        lcount_r       <= 'd1;
        o_miss_count   <= o_miss_count + 2'h1;
        o_line_missing <= 1'b1;
      end else if (lcount_r != '0 && lcount_r != '1) begin
        // The count waits at zero until the first real line after reset or a frame.
        lcount_r <= lcount_r + 1'b1;
        if (o_miss_count == 2'(MISS_MAX) && lcount_r >= lperiod_r) begin
          period_known_r <= 1'b0;
        end
      end
    end
  end

  // A count that restarted at a bridged line only measures the flywheel's own
  // guess, so the period is learnt only between two real lines.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      from_real_r <= 1'b0;
    end else if (frame_evt || miss_tick) begin
      from_real_r <= 1'b0;
    end else if (line_evt) begin
      from_real_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Line outputs
  // ----------------------------------------------------------------
  // Bridged lines still realign the sampling clock; the zero correction
  // and the line interrupt are skipped, since no reference pulse preceded them.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_line_time_zero  <= 1'b0;
      o_phase_reset     <= 1'b0;
      o_first_byte_mark <= 1'b0;
      o_zero_correct    <= 1'b0;
    end else begin
      o_line_time_zero  <= line_evt || miss_tick;
      // [RULE_05] Phase realign pulse.
      // [RULE_12] One cycle after the edge.
      o_phase_reset     <= line_evt || miss_tick;
      // [RULE_13] First byte mark.
      o_first_byte_mark <= line_evt || miss_tick;
      // [RULE_11] Zero correction real lines.
      o_zero_correct    <= line_evt;
    end
  end

  // ----------------------------------------------------------------
  // Pending interrupts
  // ----------------------------------------------------------------
  // [RULE_02] Frame interrupt set.
  // [RULE_15] Set wins over ack.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_frame_irq <= 1'b0;
    end else if (frame_evt) begin
      o_frame_irq <= 1'b1;
    end else if (i_frame_irq_ack) begin
      o_frame_irq <= 1'b0;
    end
  end

  // [RULE_04] Line interrupt set.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_line_irq <= 1'b0;
    end else if (line_evt) begin
      o_line_irq <= 1'b1;
    end else if (i_line_irq_ack) begin
      o_line_irq <= 1'b0;
    end
  end

endmodule : line_frame_sync

// ---- dv/line_frame_sync_asserts.sv ----
module sync_checks (
  input wire logic       i_clock,
  input wire logic       i_rst,
  input wire logic       i_line_pulse,
  input wire logic       i_line_window_en,
  input wire logic       i_manual_start,
  input wire logic       i_synth_frame,
  input wire logic       i_frame_irq_ack,
  input wire logic       i_line_irq_ack,
  input wire logic       o_frame_irq,
  input wire logic       o_line_irq,
  input wire logic       o_line_time_zero,
  input wire logic       o_phase_reset,
  input wire logic       o_first_byte_mark,
  input wire logic       o_zero_correct,
  input wire logic [1:0] o_miss_count
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_line_irq_set:
    assert property ($fell(i_line_pulse) && !i_line_window_en |=> o_line_irq && o_zero_correct)
    else $error("line event not flagged");
  a_tz_marks:
    assert property (o_line_time_zero |-> o_phase_reset && o_first_byte_mark)
    else $error("time zero without phase or byte mark");
  a_tz_single:
    assert property (o_line_time_zero |=> !o_line_time_zero) else $error("time zero too long");
  a_zc_real:
    assert property (o_zero_correct |-> o_line_time_zero && o_line_irq)
    else $error("zero correction on bridged line");
  a_line_pend:
    assert property (o_line_irq && !i_line_irq_ack |=> o_line_irq) else $error("line irq lost");
  a_frame_pend:
    assert property (o_frame_irq && !i_frame_irq_ack |=> o_frame_irq) else $error("frame irq lost");
  a_manual_frame:
    assert property (i_manual_start |=> o_frame_irq) else $error("manual start ignored");
  a_synth_frame:
    assert property (i_synth_frame |=> o_frame_irq) else $error("synthetic frame ignored");
  a_miss_bound:
    assert property (o_miss_count != 2'h3) else $error("too many bridged lines");
  cover property (o_frame_irq);
  cover property (o_miss_count == 2'h2);
  cover property (o_zero_correct);
endmodule : sync_checks
bind line_frame_sync sync_checks i_sync_checks (
  .i_clock           (i_clock),
  .i_rst             (i_rst),
  .i_line_pulse      (i_line_pulse),
  .i_line_window_en  (i_line_window_en),
  .i_manual_start    (i_manual_start),
  .i_synth_frame     (i_synth_frame),
  .i_frame_irq_ack   (i_frame_irq_ack),
  .i_line_irq_ack    (i_line_irq_ack),
  .o_frame_irq       (o_frame_irq),
  .o_line_irq        (o_line_irq),
  .o_line_time_zero  (o_line_time_zero),
  .o_phase_reset     (o_phase_reset),
  .o_first_byte_mark (o_first_byte_mark),
  .o_zero_correct    (o_zero_correct),
  .o_miss_count      (o_miss_count)
);

// ---- dv/line_frame_sync_tb.sv ----
module line_frame_sync_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sync_pkg::*;
  logic i_clock = 0, i_rst = 1, vid = 0, lp = 0, man = 0, syn = 0, lock = 0, wopen = 0;
  format_t fmt = FMT_OLD;
  logic fa, la, wen, win, f_irq, l_irq, tz, ph, fb, zc, miss;
  logic [1:0] mc;
  int miscompares = 0, n_compared = 0, cyc = 0;
  line_frame_sync #(.FRAME_OLD_CYC(20), .FRAME_NEW_CYC(50)) i_line_frame_sync (
    .i_clock(i_clock), .i_rst(i_rst), .i_format(fmt), .i_video_pulse(vid), .i_line_pulse(lp),
    .i_frame_window_en(wen), .i_frame_window(win), .i_line_window_en(wen),
    .i_line_window(win), .i_manual_start(man), .i_synth_frame(syn), .i_frame_irq_ack(fa),
    .i_line_irq_ack(la), .o_frame_irq(f_irq), .o_line_irq(l_irq), .o_line_time_zero(tz),
    .o_phase_reset(ph), .o_first_byte_mark(fb), .o_zero_correct(zc), .o_line_missing(miss),
    .o_miss_count(mc));
  sync_host_model i_sync_host_model (.i_clock(i_clock), .i_rst(i_rst), .i_frame_irq(f_irq),
    .i_line_irq(l_irq), .i_locked(lock), .i_win_open(wopen), .o_frame_ack(fa),
    .o_line_ack(la), .o_win_en(wen), .o_win(win));
  initial begin
    forever #12.5 i_clock = ~i_clock;
  end
  task automatic end_of_test();
    if (miscompares == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic line_pulse();
    @(posedge i_clock);
    lp <= 1;
    repeat (3) @(posedge i_clock);
    lp <= 0;
    repeat (1) @(posedge i_clock);
    #1;
  endtask : line_pulse
  task automatic t_line();
    line_pulse();
    chk("line_time_zero", 1, tz);
    chk("phase_reset", 1, ph);
    chk("first_byte_mark", 1, fb);
    chk("zero_correct", 1, zc);
    chk("line_irq", 1, l_irq);
  endtask : t_line
  task automatic t_window();
    @(posedge i_clock);
    lock <= 1;
    line_pulse();
    chk("closed window", 0, tz);
    @(posedge i_clock);
    lock <= 0;
  endtask : t_window
  task automatic t_lock_fill();
    @(posedge i_clock);
    lock  <= 1;
    wopen <= 1;
    line_pulse();
    chk("open window", 1, tz);
    t_kick(0);
    @(posedge i_clock);
    lock  <= 0;
    wopen <= 0;
  endtask : t_lock_fill
  task automatic t_missing();
    logic [7:0] ntz;
    logic [7:0] nzc;
    ntz = 8'h00;
    nzc = 8'h00;
    // A long gap first, so the first learnt period cannot bridge the spaced pulses below.
    repeat (40) @(posedge i_clock);
    repeat (3) begin
      line_pulse();
      repeat (24) @(posedge i_clock);
    end
    repeat (100) begin
      @(posedge i_clock);
      #1;
      ntz += tz;
      nzc += zc;
    end
    chk("bridged lines", 2, ntz);
    chk("bridged zero_correct", 0, nzc);
    chk("miss_count", 2, mc);
    chk("line_missing", 1, miss);
  endtask : t_missing
  task automatic t_frame(input format_t f, input int w, input logic e);
    @(posedge i_clock);
    fmt <= f;
    vid <= 1;
    repeat (w) @(posedge i_clock);
    vid <= 0;
    repeat (2) @(posedge i_clock);
    #1;
    chk("frame_irq", e, f_irq);
    repeat (12) @(posedge i_clock);
  endtask : t_frame
  task automatic t_kick(input logic m);
    @(posedge i_clock);
    man <= m;
    syn <= !m;
    @(posedge i_clock);
    man <= 0;
    syn <= 0;
    @(posedge i_clock);
    #1;
    chk("kick frame_irq", 1, f_irq);
    repeat (12) @(posedge i_clock);
  endtask : t_kick
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst <= 0;
    repeat (2) @(posedge i_clock);
    t_line();
    t_window();
    t_missing();
    t_frame(FMT_OLD, 20, 1);
    t_frame(FMT_OLD, 10, 0);
    t_frame(FMT_NEW, 50, 1);
    t_frame(FMT_NEW, 20, 0);
    t_frame(FMT_RSVD0, 20, 1);
    t_kick(1);
    t_kick(0);
    t_lock_fill();
    end_of_test();
  end
endmodule : line_frame_sync_tb

// ---- dv/sync_host_model.sv ----
module sync_host_model #(
  parameter int DLY = 4
) (
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_frame_irq,
  input  wire logic i_line_irq,
  input  wire logic i_locked,
  input  wire logic i_win_open,
  output logic      o_frame_ack,
  output logic      o_line_ack,
  output logic      o_win_en,
  output logic      o_win
);
  timeunit 1ns;
  timeprecision 100ps;
  int fc, lc;
  assign o_win_en = i_locked;
  assign o_win    = i_win_open;
  // Acks come late on purpose, so pending requests must survive the wait.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      fc <= 0;
      lc <= 0;
      o_frame_ack <= 1'b0;
      o_line_ack <= 1'b0;
    end else begin
      fc <= (i_frame_irq && !o_frame_ack) ? fc + 1 : 0;
      lc <= (i_line_irq && !o_line_ack) ? lc + 1 : 0;
      o_frame_ack <= i_frame_irq && fc == DLY;
      o_line_ack <= i_line_irq && lc == DLY;
    end
  end
endmodule : sync_host_model

// ---- include/sync_params.svh ----
`ifndef SYNC_PARAMS_SVH
`define SYNC_PARAMS_SVH
// Notes on behaviour
// [RULE_01] Frame pulse is 7 ms or 16.67 ms.
// [RULE_02] Frame trailing edge raises frame interrupt.
// [RULE_03] Line time zero is line trailing edge.
// [RULE_04] Each line pulse raises line interrupt.
// [RULE_05] Realign sampling clock at line time zero.
// [RULE_06] Host windows reject sync outside them.
// [RULE_07] Manual start pulse acts as frame sync.
// [RULE_08] Host sends synthetic frame at preset time.
// [RULE_09] Host fills missing frame sync in lock.
// [RULE_10] Survive up to two missing line pulses.
// [RULE_11] Zero correction per line unless sync missing.
// [RULE_12] First sample within half kilometre of zero.
// [RULE_13] Line sync marks first byte to packer.
// [RULE_14] Frame width counted within tolerance band.
// [RULE_15] Interrupts held pending until acknowledged.

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_FREQ_HZ        40000000
`define FRAME_OLD_US       7000
`define FRAME_NEW_US       16670
`define FRAME_OLD_CYC      ((`FRAME_OLD_US * (`CLK_FREQ_HZ / 1000000)))
`define FRAME_NEW_CYC      ((`FRAME_NEW_US * (`CLK_FREQ_HZ / 1000000)))
`define FRAME_TOL_PCT      10
`define PHASE_ERR_MAX_KM_X10 5
`endif

// ---- include/sync_pkg.sv ----
package sync_pkg;
  typedef enum logic [1:0] {
    FMT_OLD,
    FMT_NEW,
    FMT_RSVD0,
    FMT_RSVD1
  } format_t;
  typedef enum {
    LS_IDLE,
    LS_PULSE
  } pulse_state_t;
endpackage : sync_pkg
